// ---- design/sbc_pkg.sv ----
// Package of constants and carrier types for the timing, watchdog, mux and mask registers
package sbc_pkg;

    // Register addresses carried in the upper nibble of a frame
    localparam logic [3:0] ADDR_TIMING_CONTROL   = 4'ha;
    localparam logic [3:0] ADDR_WATCHDOG_STATUS  = 4'hb;
    localparam logic [3:0] ADDR_ANALOG_SELECT    = 4'hc;
    localparam logic [3:0] ADDR_CONFIGURATION    = 4'hd;
    localparam logic [3:0] ADDR_INTERRUPT_MASK   = 4'he;
    localparam logic [3:0] ADDR_INTERRUPT_SOURCE = 4'hf;

    // Frame layout
    localparam logic [3:0] FRAME_BITS      = 4'h8;
    localparam logic [3:0] ADDR_BITS       = 4'h4;
    localparam int         TARGET_SEL_BIT  = 3;

    // Values after reset
    localparam logic [2:0] WD_DIV_RESET    = 3'h0;
    localparam logic [2:0] INTERVAL_RESET  = 3'h0;
    localparam logic       DIV_SEL_RESET   = 1'h1;
    localparam logic [2:0] CHANNEL_RESET   = 3'h0;
    localparam logic [3:0] CONFIG_RESET    = 4'h0;
    localparam logic [3:0] MASK_RESET      = 4'hf;

    // Mask bit positions
    localparam int MASK_HS  = 3;
    localparam int MASK_LS  = 2;
    localparam int MASK_LIN = 1;
    localparam int MASK_VM  = 0;

    // Interval steps in milliseconds
    localparam logic [10:0] INTERVAL_STEP_MS    = 11'h014;
    localparam logic [10:0] INTERVAL_STEP_X8_MS = 11'h0a0;

    // Prescaler divider for code zero
    localparam logic [3:0] WD_DIV_UNITY = 4'h1;

    // Interrupt release pulse
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         IRQ_PULSE_US  = 10;
    localparam logic [6:0] IRQ_PULSE_CYC =
        7'((IRQ_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Serial frame states
    typedef enum logic [1:0] {
        SBC_SPI_IDLE,
        SBC_SPI_SHIFT,
        SBC_SPI_DONE
    } sbc_spi_e;

    // Watchdog inputs from the watchdog engine
    typedef struct packed {
        logic timeout_reset;   // Pulse: reset came from timeout
        logic closed_clear;    // Pulse: reset came from early clear
        logic res_missing;     // Level: config resistor missing
        logic conf_grounded;   // Level: config pin at ground
        logic window_open;     // Level: clears accepted now
    } sbc_wd_in_s;

    // Interrupt requests from the function blocks
    typedef struct packed {
        logic hs;              // High-side overtemperature
        logic ls;              // Low-side overtemperature
        logic lin;             // Bus transceiver fault
        logic vm_over;         // Supply overvoltage
        logic vm_under;        // Supply undervoltage
        logic reg_prewarn;     // Regulator overtemperature prewarning
    } sbc_irq_s;

    // Decoded control toward the analog and watchdog blocks
    typedef struct packed {
        logic [3:0]  wd_prescale_div;
        logic        wd_internal_timebase;
        logic        wd_window_enable;
        logic        wd_timeout_suppress;
        logic        direct_normal;
        logic [10:0] interval_ms;
        logic        cyclic_sense_en;
        logic        forced_wake_en;
        logic        input_divider_select;
        logic [2:0]  analog_channel_code;
        logic        analog_buf_en;
        logic        hall_supply_enable;
        logic        sense_autozero_enable;
        logic        sense_gain_select;
    } sbc_ctrl_s;

endpackage : sbc_pkg

// ---- design/sbc_sync.sv ----
// Two-stage synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
module sbc_sync
    import sbc_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RST_B,
    input  wire logic [2:0] i_pins,    // {cs_b, sclk, mosi}
    output logic [2:0]      o_level,   // Synchronised levels
    output logic [2:0]      o_rise,    // One-cycle rising edges
    output logic [2:0]      o_fall     // One-cycle falling edges
);

    // Three stages: capture, stable, previous stable
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } sbc_sync_s;

    localparam logic [2:0] PIN_IDLE = 3'h4;   // Chip select idles high

    sbc_sync_s state_reg;   // Registered stages
    sbc_sync_s state_next;  // Next stages

    // Shift the stages
    always_comb begin
        state_next    = state_reg;
        state_next.s1 = i_pins;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
    end

    // Register with synchronous reset
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            state_reg <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE};
        end else begin
            state_reg <= state_next;
        end
    end

    // Edge detection per pin, from second stage onward only
    for (genvar g = 0; g < 3; g++) begin : g_edge
        assign o_level[g] = state_reg.s2[g];
        assign o_rise[g]  = state_reg.s2[g] & ~state_reg.s3[g];
        assign o_fall[g]  = ~state_reg.s2[g] & state_reg.s3[g];
    end

endmodule : sbc_sync

// ---- design/sbc_regs.sv ----
// Serial register bank: timing, watchdog status, analog select, configuration, mask
`timescale 1ns/1ps
module sbc_regs
    import sbc_pkg::*;
(
    input  wire logic       I_CLK,          // 10 MHz system clock
    input  wire logic       I_RST_B,        // Power-on reset, active low
    input  wire logic       I_SCLK,         // Serial clock pin
    input  wire logic       I_CS_B,         // Chip select pin, active low
    input  wire logic       I_MOSI,         // Serial data in pin
    output logic            O_MISO,         // Serial data out
    output logic            O_MISO_OE,      // Serial out drive enable
    input  wire logic       I_MODE_RESET,   // Reset mode or external reset
    input  wire logic       I_LOW_POWER,    // Stop or Sleep mode
    input  wire logic       I_HS_ON,        // Any high-side switch on
    input  wire sbc_wd_in_s I_WD,           // Watchdog engine status
    input  wire logic [3:0] I_INT_SOURCE,   // Interrupt source nibble
    input  wire logic       I_INT_PENDING,  // Interrupt still pending
    input  wire sbc_irq_s   I_IRQ_REQ,      // Raw interrupt requests
    output sbc_irq_s        O_IRQ_PASS,     // Requests after masking
    output logic            O_IRQ_B,        // Interrupt pin, active low
    output logic            O_INT_ACK,      // Source read acknowledge
    output sbc_ctrl_s       O_CTRL          // Decoded control outputs
);

    // Whole state of the bank
    typedef struct packed {
        sbc_spi_e   st;          // Frame state
        logic [3:0] cnt;         // Bits received
        logic [7:0] rx;          // Received frame
        logic [3:0] tx;          // Answer nibble being sent
        logic       miso;        // Serial out bit
        logic       miso_oe;     // Serial out enable
        logic [2:0] wd_div;      // Watchdog divider code
        logic [2:0] interval;    // Sense interval code
        logic       watchdog_timeout_flag;        // Watchdog timeout flag
        logic       div_sel;     // Input divider select
        logic [2:0] chan;        // Analog channel code
        logic       hall;        // Hall supply enable
        logic       x8;          // Interval times eight
        logic       az;          // Auto-zero enable
        logic       gain;        // Gain select
        logic [3:0] mask;        // Interrupt enables
        logic       lp_d;        // Previous low-power level
        logic       hs_latched;  // High side on at low-power entry
        logic       irq_b;       // Interrupt pin level
        logic [6:0] pulse;       // Release pulse counter
        logic       ack;         // Acknowledge pulse
        sbc_irq_s   pass;        // Masked requests
        sbc_ctrl_s  ctrl;        // Decoded control
    } sbc_regs_s;

    sbc_regs_s   state_reg;      // Registered state
    sbc_regs_s   state_next;     // Next state
    logic [2:0]  pin_level;      // Synchronised pins
    logic [2:0]  pin_rise;       // Pin rising edges
    logic [2:0]  pin_fall;       // Pin falling edges
    logic        cs_b;           // Synchronised chip select
    logic        sclk_rise;      // Serial clock rising
    logic        sclk_fall;      // Serial clock falling
    logic        mosi;           // Synchronised data in
    logic [3:0]  addr_now;       // Address once four bits are in
    logic [3:0]  data_now;       // Data once eight bits are in
    logic [3:0]  answer;         // Answer for the current address
    logic        watchdog_timeout_flag_clear;     // Access clears timeout flag
    logic        window_active;  // Windowed watchdog active

    // Pins pass two flip-flops before use
    sbc_sync u_sync (
        .I_CLK   (I_CLK),
        .I_RST_B (I_RST_B),
        .i_pins  ({I_CS_B, I_SCLK, I_MOSI}),
        .o_level (pin_level),
        .o_rise  (pin_rise),
        .o_fall  (pin_fall)
    );

    // Split the synchronised bundle into its pins
    assign cs_b      = pin_level[2];
    assign sclk_rise = pin_rise[1];
    assign sclk_fall = pin_fall[1];
    assign mosi      = pin_level[0];
    // Both nibbles end with the bit on the current rise
    assign addr_now  = {state_reg.rx[2:0], mosi};
    assign data_now  = {state_reg.rx[2:0], mosi};

    // Answer nibble chosen once the address is known
    always_comb begin
        answer = 4'h0;
        case (addr_now)
            ADDR_TIMING_CONTROL,
            ADDR_WATCHDOG_STATUS: begin
                answer = {state_reg.watchdog_timeout_flag, I_WD.res_missing,
                          I_WD.conf_grounded, I_WD.window_open};
            end
            ADDR_INTERRUPT_MASK,
            ADDR_INTERRUPT_SOURCE: begin
                answer = I_INT_SOURCE;
            end
            default: begin
                answer = 4'h0;                                   // Unmapped reads zero
            end
        endcase
    end

    // Windowing runs only with resistor present and watchdog on
    assign window_active = ~I_WD.res_missing & ~I_WD.conf_grounded;

    // Next-state logic
    always_comb begin
        state_next      = state_reg;
        state_next.ack  = 1'b0;
        state_next.lp_d = I_LOW_POWER;
        watchdog_timeout_flag_clear      = 1'b0;

        // Serial frame handling
        // Enable trails chip select by the sync delay
        state_next.miso_oe = ~cs_b;
        case (state_reg.st)
            SBC_SPI_IDLE: begin
                // Wait for chip select
                state_next.miso = 1'b0;
                if (!cs_b) begin
                    state_next.st  = SBC_SPI_SHIFT;
                    state_next.cnt = 4'h0;
                    state_next.rx  = 8'h00;
                end
            end
            SBC_SPI_SHIFT: begin
                if (cs_b) begin
                    // Frame cut short: nothing takes effect
                    state_next.st = SBC_SPI_IDLE;
                end else if (sclk_rise) begin
                    state_next.rx  = {state_reg.rx[6:0], mosi};
                    state_next.cnt = state_reg.cnt + 4'h1;
                    // Address complete: capture answer before any clear
                    if (state_reg.cnt == ADDR_BITS - 4'h1) begin
                        state_next.tx = answer;
                    end
                    if (state_reg.cnt == FRAME_BITS - 4'h1) begin
                        // Whole frame in: commit the access
                        state_next.st = SBC_SPI_DONE;
                        case (state_reg.rx[6:3])
                            ADDR_TIMING_CONTROL: begin
                                // Top data bit routes the code
                                if (data_now[TARGET_SEL_BIT]) begin
                                    state_next.interval = data_now[2:0];
                                end else begin
                                    state_next.wd_div = data_now[2:0];
                                end
                                watchdog_timeout_flag_clear = 1'b1;
                            end
                            ADDR_WATCHDOG_STATUS: begin
                                // Status read only clears the flag
                                watchdog_timeout_flag_clear = 1'b1;
                            end
                            ADDR_ANALOG_SELECT: begin
                                // Divider select and channel code
                                state_next.div_sel = data_now[3];
                                state_next.chan    = data_now[2:0];
                            end
                            ADDR_CONFIGURATION: begin
                                // Hall, times eight, auto-zero, gain
                                state_next.hall = data_now[3];
                                state_next.x8   = data_now[2];
                                state_next.az   = data_now[1];
                                state_next.gain = data_now[0];
                            end
                            ADDR_INTERRUPT_MASK: begin
                                // One enable per maskable block
                                state_next.mask = data_now;
                            end
                            ADDR_INTERRUPT_SOURCE: begin
                                // Source read acknowledges the interrupt
                                state_next.ack = 1'b1;
                            end
                            default: begin
                                // Unmapped address: no effect
                            end
                        endcase
                    end
                end else if (sclk_fall && state_reg.cnt >= ADDR_BITS) begin
                    // Answer nibble, most significant bit first
                    state_next.miso = state_reg.tx[3];
                    state_next.tx   = {state_reg.tx[2:0], 1'b0};
                end else if (sclk_fall) begin
                    // Address phase sends zeros
                    state_next.miso = 1'b0;
                end
            end
            SBC_SPI_DONE: begin
                // Extra clocks ignored until chip select rises
                if (cs_b) begin
                    state_next.st = SBC_SPI_IDLE;
                end
            end
            default: begin
                state_next.st = SBC_SPI_IDLE;
            end
        endcase

        // Timeout flag: set wins over clear
        state_next.watchdog_timeout_flag = I_WD.timeout_reset | I_WD.closed_clear
                        | (state_reg.watchdog_timeout_flag & ~watchdog_timeout_flag_clear);

        // Reset mode or external reset clears selected fields
        if (I_MODE_RESET) begin
            // Other control fields only return on power-on reset
            state_next.chan = CHANNEL_RESET;
            state_next.hall = CONFIG_RESET[3];
        end

        // Latch high-side state on entry to Stop or Sleep
        if (I_LOW_POWER && !state_reg.lp_d) begin
            // Decides cyclic sense against forced wake-up
            state_next.hs_latched = I_HS_ON;
        end

        // Interrupt pin: release on acknowledge, pulse if still pending
        if (state_reg.ack) begin
            state_next.irq_b = 1'b1;
            state_next.pulse = IRQ_PULSE_CYC - 7'h1;
        end else if (state_reg.pulse != 7'h0) begin
            // Hold released until the count runs out
            state_next.irq_b = 1'b1;
            state_next.pulse = state_reg.pulse - 7'h1;
        end else begin
            // Otherwise follow the pending level
            state_next.irq_b = ~I_INT_PENDING;
        end

        // Interrupt masking
        state_next.pass.hs          = I_IRQ_REQ.hs & state_reg.mask[MASK_HS];
        state_next.pass.ls          = I_IRQ_REQ.ls & state_reg.mask[MASK_LS];
        state_next.pass.lin         = I_IRQ_REQ.lin & state_reg.mask[MASK_LIN];
        state_next.pass.vm_over     = I_IRQ_REQ.vm_over & state_reg.mask[MASK_VM];
        state_next.pass.vm_under    = I_IRQ_REQ.vm_under;
        state_next.pass.reg_prewarn = I_IRQ_REQ.reg_prewarn;

        // Decoded watchdog control
        if (window_active && state_reg.wd_div != 3'h0) begin
            state_next.ctrl.wd_prescale_div = {state_reg.wd_div, 1'b0};
        end else begin
            state_next.ctrl.wd_prescale_div = WD_DIV_UNITY;
        end
        // Resistor and pin conditions pass straight through
        state_next.ctrl.wd_internal_timebase = I_WD.res_missing;
        state_next.ctrl.wd_window_enable     = window_active;
        state_next.ctrl.wd_timeout_suppress  = I_WD.conf_grounded;
        state_next.ctrl.direct_normal        = I_WD.conf_grounded;

        // Decoded interval control
        state_next.ctrl.interval_ms = 11'(state_reg.interval)
            * (state_reg.x8 ? INTERVAL_STEP_X8_MS : INTERVAL_STEP_MS);
        state_next.ctrl.cyclic_sense_en = I_LOW_POWER && state_reg.interval != 3'h0
                                          && state_reg.hs_latched;
        state_next.ctrl.forced_wake_en  = I_LOW_POWER && state_reg.interval != 3'h0
                                          && !state_reg.hs_latched;

        // Decoded analog control
        state_next.ctrl.input_divider_select  = state_reg.div_sel;
        state_next.ctrl.analog_channel_code   = state_reg.chan;
        // Buffer unpowered when disabled or in low power
        state_next.ctrl.analog_buf_en = state_reg.chan != 3'h0 && !I_LOW_POWER;
        state_next.ctrl.hall_supply_enable    = state_reg.hall;
        state_next.ctrl.sense_autozero_enable = state_reg.az;
        state_next.ctrl.sense_gain_select     = state_reg.gain;
    end

    // State register with power-on reset
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            state_reg            <= '0;
            state_reg.st         <= SBC_SPI_IDLE;
            state_reg.wd_div     <= WD_DIV_RESET;
            state_reg.interval   <= INTERVAL_RESET;
            state_reg.div_sel    <= DIV_SEL_RESET;
            state_reg.chan       <= CHANNEL_RESET;
            state_reg.hall       <= CONFIG_RESET[3];
            state_reg.x8         <= CONFIG_RESET[2];
            state_reg.az         <= CONFIG_RESET[1];
            state_reg.gain       <= CONFIG_RESET[0];
            state_reg.mask       <= MASK_RESET;
            // Interrupt pin idles released
            state_reg.irq_b      <= 1'b1;
            // Decoded outputs start from the register reset values
            state_reg.ctrl.wd_prescale_div      <= WD_DIV_UNITY;
            state_reg.ctrl.input_divider_select <= DIV_SEL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign O_MISO     = state_reg.miso;
    assign O_MISO_OE  = state_reg.miso_oe;
    assign O_IRQ_PASS = state_reg.pass;
    assign O_IRQ_B    = state_reg.irq_b;
    assign O_INT_ACK  = state_reg.ack;
    assign O_CTRL     = state_reg.ctrl;

endmodule : sbc_regs

// ---- tb/sbc_regs_monitor.sv ----
// Port checker for the serial register bank
`timescale 1ns/1ps
module sbc_regs_monitor
    import sbc_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_RST_B,
    input wire logic       I_MODE_RESET,
    input wire logic       I_LOW_POWER,
    input wire sbc_wd_in_s I_WD,
    input wire sbc_irq_s   I_IRQ_REQ,
    input wire sbc_irq_s   O_IRQ_PASS,
    input wire logic       O_IRQ_B,
    input wire logic       O_INT_ACK,
    input wire sbc_ctrl_s  O_CTRL
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    a_pass_needs_req: assert property ((O_IRQ_PASS & ~$past(I_IRQ_REQ)) == 6'h00)
        else $error("Pass without request");
    a_unmaskable_pass: assert property ($past(I_RST_B) |->
        {O_IRQ_PASS.vm_under, O_IRQ_PASS.reg_prewarn}
        == $past({I_IRQ_REQ.vm_under, I_IRQ_REQ.reg_prewarn})) else $error("Unmaskable lost");
    a_div_no_window: assert property (!O_CTRL.wd_window_enable |->
        O_CTRL.wd_prescale_div == 4'h1) else $error("Prescaler without window");
    a_res_missing: assert property (I_WD.res_missing |=>
        O_CTRL.wd_internal_timebase && !O_CTRL.wd_window_enable) else $error("Resistor flag");
    a_pin_grounded: assert property (I_WD.conf_grounded |=>
        O_CTRL.wd_timeout_suppress && O_CTRL.direct_normal) else $error("Grounded pin");
    a_low_power_buf: assert property (I_LOW_POWER |=> !O_CTRL.analog_buf_en)
        else $error("Buffer on in low power");
    a_mode_reset_clr: assert property (I_MODE_RESET |-> ##2
        O_CTRL.analog_channel_code == 3'h0 && !O_CTRL.hall_supply_enable) else $error("Mode reset");
    a_ack_release: assert property (O_INT_ACK |=> O_IRQ_B [*8])
        else $error("Interrupt pin not released");
endmodule : sbc_regs_monitor
bind sbc_regs sbc_regs_monitor sbc_regs_monitor_inst (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_MODE_RESET(I_MODE_RESET), .I_LOW_POWER(I_LOW_POWER), .I_WD(I_WD),
    .I_IRQ_REQ(I_IRQ_REQ), .O_IRQ_PASS(O_IRQ_PASS), .O_IRQ_B(O_IRQ_B),
    .O_INT_ACK(O_INT_ACK), .O_CTRL(O_CTRL));

// ---- tb/sbc_host_model.sv ----
// Host model driving the serial register link
`timescale 1ns/1ps
module sbc_host_model (
    input  wire logic I_CLK,
    input  wire logic i_miso,
    output logic      o_sclk,
    output logic      o_cs_b,
    output logic      o_mosi
);
    // Link clock idle low, chip deselected
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end
    // One frame out, answer nibble back on rises five to eight
    task automatic xfer(input logic [7:0] tx, output logic [3:0] rx);
        rx = 4'h0;
        o_cs_b <= 1'b0;
        repeat (4) @(posedge I_CLK);
        for (int i = 7; i >= 0; i--) begin
            o_mosi <= tx[i];
            repeat (4) @(posedge I_CLK);
            o_sclk <= 1'b1;
            if (i < 4) rx[i] = i_miso;
            repeat (4) @(posedge I_CLK);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge I_CLK);
        o_cs_b <= 1'b1;
        o_mosi <= ~o_mosi;  // Released data line flips
        repeat (4) @(posedge I_CLK);
    endtask : xfer
endmodule : sbc_host_model

// ---- tb/test_sbc_regs.sv ----
// Self-checking bench for the serial register bank
`timescale 1ns/1ps
module test_sbc_regs
    import sbc_pkg::*;
;
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
    logic       clk = 1'b0, rst_b = 1'b0, mode_rst = 1'b0, low_pwr = 1'b0, hs_on = 1'b0;
    logic       pend = 1'b0, sclk, cs_b, mosi, miso, miso_oe, ack, irq_b;
    logic [3:0] src = 4'h0, rx, cfg, u;
    sbc_wd_in_s wd = 5'h00;
    sbc_irq_s   req = 6'h00, pass;
    sbc_ctrl_s  ctrl;
    int         n_errors = 0, total_checks = 0, n_ack = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (ack) n_ack++;  // Count acknowledge pulses
    sbc_regs sbc_regs_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_SCLK(sclk), .I_CS_B(cs_b),
        .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE(miso_oe), .I_MODE_RESET(mode_rst),
        .I_LOW_POWER(low_pwr), .I_HS_ON(hs_on), .I_WD(wd), .I_INT_SOURCE(src),
        .I_INT_PENDING(pend), .I_IRQ_REQ(req), .O_IRQ_PASS(pass), .O_IRQ_B(irq_b),
        .O_INT_ACK(ack), .O_CTRL(ctrl));
    // Released data line reads inverted at the host
    sbc_host_model sbc_host_model_inst (.I_CLK(clk), .i_miso(miso_oe ? miso : ~miso),
        .o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi));
    // Expected divider and interval
    function automatic logic [3:0] div_of(logic [2:0] c);
        return (c == 3'h0) ? 4'h1 : 4'(2 * c);
    endfunction : div_of
    function automatic logic [10:0] ms_of(logic [2:0] c, logic x8);
        return 11'(c * (x8 ? 160 : 20));
    endfunction : ms_of
    task automatic wr(input logic [7:0] f);
        sbc_host_model_inst.xfer(f, rx);
    endtask : wr
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Hang guard
    initial begin
        #3000000;
        n_errors++;
        end_sim;
    end
    // Main sequence
    initial begin
        void'($urandom(27447));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        req <= 6'h3f;
        repeat (4) @(posedge clk);
        `CHK("div", 4'h1, ctrl.wd_prescale_div)
        `CHK("input_divider_select", 1'b1, ctrl.input_divider_select)
        `CHK("mask", 6'h3f, pass)
        req <= 6'h00;
        wd.window_open <= 1'b1;
        $display("reset done");
        for (int c = 0; c < 8; c++) begin
            wr({5'h14, 3'(c)});
            `CHK("status", 4'h1, rx)
            `CHK("div", div_of(3'(c)), ctrl.wd_prescale_div)
            `CHK("oe", 1'b0, miso_oe)
        end
        for (int n = 0; n < 16; n++) begin
            u = 4'($urandom);
            cfg = {u[3], n[3], u[1:0]};
            wr({4'hd, cfg});
            wr({5'h15, n[2:0]});
            `CHK("ms", ms_of(n[2:0], cfg[2]), ctrl.interval_ms)
            `CHK("div", 4'he, ctrl.wd_prescale_div)
            `CHK("cfg", {cfg[3], cfg[1:0]}, {ctrl.hall_supply_enable,
                ctrl.sense_autozero_enable, ctrl.sense_gain_select})
        end
        $display("timing done");
        wd.timeout_reset <= 1'b1;
        @(posedge clk) wd.timeout_reset <= 1'b0;
        wr(8'hb0);
        `CHK("flag", 4'h9, rx)
        wr(8'hb0);
        `CHK("flag", 4'h1, rx)
        wd.closed_clear <= 1'b1;
        @(posedge clk) wd.closed_clear <= 1'b0;
        wr(8'ha7);
        `CHK("flag", 4'h9, rx)
        wr(8'h35);
        `CHK("unmapped", 4'h0, rx)
        wd.res_missing <= 1'b1;
        wr(8'ha3);
        `CHK("err", 3'h2, rx[3:1])
        `CHK("div", 4'h1, ctrl.wd_prescale_div)
        wd <= 5'h03;
        wr(8'hb0);
        `CHK("off", 4'h3, rx)
        wd <= 5'h01;
        $display("watchdog done");
        wr(8'hcb);
        wr(8'hca);  // Through battery sense to temperature
        `CHK("chan", 5'h1a, {ctrl.analog_buf_en, ctrl.input_divider_select,
            ctrl.analog_channel_code})
        hs_on <= 1'b1;
        @(posedge clk) low_pwr <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("cyc", 3'h4, {ctrl.cyclic_sense_en, ctrl.forced_wake_en, ctrl.analog_buf_en})
        low_pwr <= 1'b0;
        hs_on <= 1'b0;
        @(posedge clk) low_pwr <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("wake", 2'h1, {ctrl.cyclic_sense_en, ctrl.forced_wake_en})
        low_pwr <= 1'b0;
        wr(8'hd8);
        `CHK("hall", 1'b1, ctrl.hall_supply_enable)
        mode_rst <= 1'b1;
        repeat (2) @(posedge clk) mode_rst <= 1'b0;
        @(posedge clk);
        `CHK("modrst", 5'h10, {ctrl.input_divider_select, ctrl.analog_channel_code,
            ctrl.hall_supply_enable})
        $display("analog done");
        src <= 4'($urandom);
        wr(8'he0);
        `CHK("src", src, rx)
        req <= 6'h3f;
        wr(8'he1);
        `CHK("vm", 6'h07, pass)
        wr(8'he2);
        `CHK("mask", 6'h0b, pass)
        req <= 6'h00;
        pend <= 1'b1;
        wr(8'hf0);
        `CHK("irq", 1'b1, irq_b)
        `CHK("ack", 1, n_ack)
        repeat (100) @(posedge clk);
        `CHK("irq", 1'b0, irq_b)
        $display("interrupt done");
        end_sim;
    end
endmodule : test_sbc_regs
